/* hdl/fic_ctrl.v */
/*
 Flash in-application programming control: mode/command register, chip
 reset pattern, buffer clear, address and data words, write-enable
 procedure with timeout and pattern check, and a flash array handshake.
 Assumes a byte register port synchronous to clock_in and a flash array
 that pulses done for each started operation.
*/
`include "fic_regs.vh"

module fic_ctrl
#(
    parameter ADDR_HI_BITS = 7,
    parameter TIMEOUT_CYCLES = `FIC_TIMEOUT_CYCLES
)
(
    input wire clock_in,
    input wire rst_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    output reg [7:0] reg_rdata_out,
    output reg cpu_stall_out,
    output reg chip_reset_out,
    output reg flash_write_out,
    output reg flash_erase_out,
    output reg flash_read_out,
    output reg flash_buf_clear_out,
    output reg [14:0] flash_addr_out,
    output reg [63:0] flash_wdata_out,
    output reg write_enabled_out,
    input wire flash_done_in
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_BUSY = 4'b0010;
    localparam ST_WEN = 4'b0100;
    localparam ST_DONE = 4'b1000;
    localparam [14:0] ADDR_HI_MASK = (15'h0001 << (8 + ADDR_HI_BITS)) - 15'h0001;

    reg [7:0] mode_cmd_reg;
    reg [7:0] rst_pat_reg;
    reg buf_clr_reg;
    reg [7:0] addr_lo_reg;
    reg [7:0] addr_hi_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg [31:0] timer_reg;
    reg rd_sel_reg;
    reg [3:0] rd_addr_reg;
    reg [7:0] rd_mux;
    wire [63:0] data_bytes;
    wire [7:0] mem_rdata;
    wire [2:0] mode;
    wire in_data;
    wire pattern_ok;
    wire ack;
    wire [3:0] data_idx;
    wire op_ok;

    assign mode = mode_cmd_reg[`FIC_BIT_MODE_HI:`FIC_BIT_MODE_LO];
    assign data_idx = reg_addr_in - `FIC_OFS_DATA0;
    // Operation the array can serve; anything else ends without a strobe
    assign op_ok = mode_cmd_reg[`FIC_BIT_WR_START] ? (mode_cmd_reg[`FIC_BIT_WEN_STAT] &&
        (mode == `FIC_MODE_WRITE || mode == `FIC_MODE_ERASE)) :
        (buf_clr_reg || mode == `FIC_MODE_READ); // R20
    assign in_data = reg_addr_in >= `FIC_OFS_DATA0 && reg_addr_in <= (`FIC_OFS_DATA0 + 4'h7);
    assign ack = flash_done_in;
    assign pattern_ok = data_bytes[23:16] == `FIC_PAT_0 && data_bytes[31:24] == `FIC_PAT_1 &&
        data_bytes[39:32] == `FIC_PAT_2 && data_bytes[47:40] == `FIC_PAT_3 &&
        data_bytes[55:48] == `FIC_PAT_4 && data_bytes[63:56] == `FIC_PAT_5; // R17

    fic_data_mem u_mem
    (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_en_in(reg_wr_in && in_data),
        .wr_idx_in(data_idx[2:0]),
        .wr_data_in(reg_wdata_in),
        .rd_idx_in(data_idx[2:0]),
        .rd_data_out(mem_rdata),
        .all_bytes_out(data_bytes)
    );

    // ==========================================
    // Sequencer
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (mode_cmd_reg[`FIC_BIT_PROC_EN] && mode == `FIC_MODE_WEN)
                    state_next = ST_WEN; // R4
                else if (mode_cmd_reg[`FIC_BIT_WR_START] || buf_clr_reg)
                    state_next = ST_BUSY;
                else if (mode_cmd_reg[`FIC_BIT_RD_START] && mode_cmd_reg[`FIC_BIT_RD_EN])
                    state_next = ST_BUSY; // R7
                else if (mode_cmd_reg[`FIC_BIT_RD_START])
                    state_next = ST_DONE;
            end
            ST_BUSY:
                if (ack || !op_ok)
                    state_next = ST_DONE; // R20
            ST_WEN:
                if (timer_reg >= TIMEOUT_CYCLES - 1)
                    state_next = ST_DONE; // R18
            ST_DONE:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    // ==========================================
    // Registers and control state
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_IDLE;
            mode_cmd_reg <= `FIC_MODE_CMD_RESET;
            rst_pat_reg <= 8'h00;
            buf_clr_reg <= 1'b0;
            addr_lo_reg <= 8'h00;
            addr_hi_reg <= 8'h00;
            timer_reg <= 32'h0000_0000;
            rd_sel_reg <= 1'b0;
            rd_addr_reg <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
            if (reg_rd_in)
            begin
                rd_sel_reg <= in_data;
                rd_addr_reg <= reg_addr_in;
            end
            timer_reg <= (state_reg == ST_WEN) ? timer_reg + 32'h0000_0001 : 32'h0000_0000;
            if (reg_wr_in)
            begin
                case (reg_addr_in)
                    `FIC_OFS_MODE_CMD:
                    begin
                        mode_cmd_reg[6:0] <= reg_wdata_in[6:0]; // R1 R2 R3 R6 R8
                        if (!reg_wdata_in[`FIC_BIT_WEN_STAT])
                            mode_cmd_reg[`FIC_BIT_WEN_STAT] <= 1'b0; // R16
                    end
                    `FIC_OFS_RST_PAT: rst_pat_reg <= reg_wdata_in;
                    `FIC_OFS_BUF_CLR: buf_clr_reg <= reg_wdata_in[`FIC_BIT_BUF_CLR]; // R10
                    `FIC_OFS_ADDR_LO: addr_lo_reg <= reg_wdata_in; // R12
                    `FIC_OFS_ADDR_HI: addr_hi_reg <= reg_wdata_in & {1'b0, ADDR_HI_MASK[14:8]}; // R13 R14
                    default: ;
                endcase
            end
            if (state_reg == ST_DONE)
            begin
                if (mode_cmd_reg[`FIC_BIT_PROC_EN] && mode == `FIC_MODE_WEN)
                begin
                    mode_cmd_reg[`FIC_BIT_PROC_EN] <= 1'b0; // R3
                    if (pattern_ok)
                        mode_cmd_reg[`FIC_BIT_WEN_STAT] <= 1'b1; // R5 R16
                end
                else if (mode_cmd_reg[`FIC_BIT_WR_START])
                    mode_cmd_reg[`FIC_BIT_WR_START] <= 1'b0; // R6
                else if (buf_clr_reg)
                    buf_clr_reg <= 1'b0; // R10
                else
                    mode_cmd_reg[`FIC_BIT_RD_START] <= 1'b0; // R8
            end
        end
    end

    // ==========================================
    // Flash array strobes and outputs
    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cpu_stall_out <= 1'b0;
            chip_reset_out <= 1'b0;
            flash_write_out <= 1'b0;
            flash_erase_out <= 1'b0;
            flash_read_out <= 1'b0;
            flash_buf_clear_out <= 1'b0;
            flash_addr_out <= 15'h0000;
            flash_wdata_out <= 64'h0000_0000_0000_0000;
            write_enabled_out <= 1'b0;
        end
        else
        begin
            cpu_stall_out <= state_next == ST_BUSY || state_reg == ST_BUSY ||
                (state_reg == ST_IDLE &&
                (mode_cmd_reg[`FIC_BIT_WR_START] || mode_cmd_reg[`FIC_BIT_RD_START])); // R19
            chip_reset_out <= reg_wr_in && reg_addr_in == `FIC_OFS_RST_PAT &&
                reg_wdata_in == `FIC_RESET_MAGIC; // R9
            flash_write_out <= state_reg == ST_BUSY && mode_cmd_reg[`FIC_BIT_WR_START] &&
                mode_cmd_reg[7] && mode == `FIC_MODE_WRITE; // R1 R20
            flash_erase_out <= state_reg == ST_BUSY && mode_cmd_reg[`FIC_BIT_WR_START] &&
                mode_cmd_reg[7] && mode == `FIC_MODE_ERASE; // R1 R20
            flash_read_out <= state_reg == ST_BUSY && !mode_cmd_reg[`FIC_BIT_WR_START] &&
                !buf_clr_reg && mode == `FIC_MODE_READ; // R1 R7
            flash_buf_clear_out <= state_reg == ST_BUSY && !mode_cmd_reg[`FIC_BIT_WR_START] &&
                buf_clr_reg;
            flash_addr_out <= {addr_hi_reg[6:0], addr_lo_reg} & ADDR_HI_MASK;
            flash_wdata_out <= data_bytes;
            write_enabled_out <= mode_cmd_reg[`FIC_BIT_WEN_STAT];
        end
    end

    // ==========================================
    // Read back
    always @*
    begin
        case (rd_addr_reg)
            `FIC_OFS_MODE_CMD: rd_mux = mode_cmd_reg;
            `FIC_OFS_RST_PAT: rd_mux = rst_pat_reg;
            `FIC_OFS_BUF_CLR: rd_mux = {7'h00, buf_clr_reg}; // R11
            `FIC_OFS_ADDR_LO: rd_mux = addr_lo_reg;
            `FIC_OFS_ADDR_HI: rd_mux = addr_hi_reg;
            default: rd_mux = rd_sel_reg ? mem_rdata : 8'h00;
        endcase
    end

    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            reg_rdata_out <= 8'h00;
        else
            reg_rdata_out <= rd_mux;
    end
endmodule

/* hdl/fic_regs.vh */
/*
 Register offsets, field positions, reset values and timing counts
 for the flash in-application programming control block.
 Assumes a byte-wide special register port; offsets are local indices.
*/
// Notes on behaviour
// R1: Mode 000 write, 001 erase, 011 read
// R2: Mode 110 enables writing; others reserved
// R3: Procedure-enable bit set by software, hardware clears
// R4: Procedure bit plus mode 110 runs enabling
// R5: Write-enabled state persists after success
// R6: Write-start bit cleared when write/erase done
// R7: Read-enable bit gates flash read access
// R8: Read-start bit cleared when read done
// R9: Writing 55H to pattern register resets chip
// R10: Buffer-clear bit cleared when clear completes
// R11: Buffer-clear register bits 7..1 read zero
// R12: Address low holds address bits 7..0
// R13: Small variant: address high bits 13..8
// R14: Large variant: address high bits 14..8
// R15: Four 16-bit data words, low/high bytes
// R16: Write-enabled bit set by hardware only
// R17: Pattern 00,04,0D,09,C3,40 into words 1..3
// R18: 300us timeout, then pattern check and clear
// R19: Processor stalled while start bits set
// R20: Write/erase ignored when writing not enabled
`ifndef FIC_REGS_VH
`define FIC_REGS_VH

`define FIC_OFS_MODE_CMD 4'h0
`define FIC_OFS_RST_PAT 4'h1
`define FIC_OFS_BUF_CLR 4'h2
`define FIC_OFS_ADDR_LO 4'h3
`define FIC_OFS_ADDR_HI 4'h4
`define FIC_OFS_DATA0 4'h5

`define FIC_BIT_WEN_STAT 7
`define FIC_BIT_MODE_HI 6
`define FIC_BIT_MODE_LO 4
`define FIC_BIT_PROC_EN 3
`define FIC_BIT_WR_START 2
`define FIC_BIT_RD_EN 1
`define FIC_BIT_RD_START 0
`define FIC_BIT_BUF_CLR 0

`define FIC_MODE_CMD_RESET 8'h70
`define FIC_MODE_WRITE 3'h0
`define FIC_MODE_ERASE 3'h1
`define FIC_MODE_READ 3'h3
`define FIC_MODE_WEN 3'h6
`define FIC_RESET_MAGIC 8'h55

`define FIC_PAT_0 8'h00
`define FIC_PAT_1 8'h04
`define FIC_PAT_2 8'h0d
`define FIC_PAT_3 8'h09
`define FIC_PAT_4 8'hc3
`define FIC_PAT_5 8'h40

`define FIC_TIMEOUT_NS 300000
`define FIC_CLK_PERIOD_NS 10
`define FIC_TIMEOUT_CYCLES (`FIC_TIMEOUT_NS / `FIC_CLK_PERIOD_NS)

`endif

/* hdl/fic_data_mem.v */
/*
 Eight-byte data word store: four 16-bit words as low/high bytes.
 Assumes one write port; read data and pattern bytes come from registers.
*/
module fic_data_mem
(
    input wire clock_in,
    input wire rst_in,
    input wire wr_en_in,
    input wire [2:0] wr_idx_in,
    input wire [7:0] wr_data_in,
    input wire [2:0] rd_idx_in,
    output reg [7:0] rd_data_out,
    output wire [63:0] all_bytes_out
);
    reg [7:0] byte_reg [0:7];
    genvar gi;

    // ==========================================
    // Byte storage
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_byte
            always @(posedge clock_in or posedge rst_in)
            begin
                if (rst_in)
                    byte_reg[gi] <= 8'h00;
                else if (wr_en_in && wr_idx_in == gi)
                    byte_reg[gi] <= wr_data_in; // R15
            end
            assign all_bytes_out[gi*8 +: 8] = byte_reg[gi];
        end
    endgenerate

    always @(posedge clock_in or posedge rst_in)
    begin
        if (rst_in)
            rd_data_out <= 8'h00;
        else
            rd_data_out <= byte_reg[rd_idx_in];
    end
endmodule

/* sim/fic_flash_model.sv */
/* Flash array stand-in: one done pulse per busy period, after delay_in cycles.
   Assumes the controller holds its strobe high until done. */
module fic_flash_model
(
    input wire clock_in,
    input wire rst_in,
    input wire busy_in,
    input wire [7:0] delay_in,
    output logic done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // ==========
    // Done once per operation, after the programmed wait
    always @(posedge clock_in or posedge rst_in)
    begin
        done_out <= 1'h0;
        cnt <= (rst_in || !busy_in) ? 0 : cnt + 1;
        if (!rst_in && busy_in && cnt == delay_in)
            done_out <= 1'h1;
    end
endmodule

/* sim/fic_ctrl_monitor.sv */
/* Port checker for fic_ctrl.
   Assumes one clock domain with async active-high reset. */
module fic_ctrl_monitor
#(
    parameter ADDR_HI_BITS = 7
)
(
    input wire clock_in,
    input wire rst_in,
    input wire reg_wr_in,
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire cpu_stall_out,
    input wire chip_reset_out,
    input wire flash_write_out,
    input wire flash_erase_out,
    input wire flash_read_out,
    input wire flash_buf_clear_out,
    input wire [14:0] flash_addr_out,
    input wire write_enabled_out,
    input wire flash_done_in
);
    wire [3:0] busy = {flash_buf_clear_out, flash_read_out, flash_erase_out, flash_write_out};
    default clocking mon_cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    // ==========
    // Assertions
    reset_pulse_a: assert property (
        reg_wr_in && reg_addr_in == 4'h1 && reg_wdata_in == 8'h55 |-> ##[1:2] chip_reset_out)
        else $error("no chip reset after magic write");
    pulse_once_a: assert property (chip_reset_out |=> !chip_reset_out)
        else $error("chip reset longer than one cycle");
    write_guard_a: assert property ($rose(|busy[1:0]) |-> write_enabled_out)
        else $error("write or erase while not enabled");
    cpu_stall_a: assert property (|busy[2:0] |-> cpu_stall_out)
        else $error("flash busy without stall");
    one_op_a: assert property ($onehot0(busy))
        else $error("two flash operations at once");
    strobe_hold_a: assert property ($fell(|busy) |->
        $past(flash_done_in) || $past(flash_done_in, 2) || $past(flash_done_in, 3))
        else $error("strobe dropped without done");
    op_end_a: assert property (flash_done_in |-> ##[1:3] busy == 4'h0)
        else $error("strobe stays after done");
    status_sw_a: assert property (
        reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[7] && !write_enabled_out
        |-> ##2 !write_enabled_out) else $error("software set write enable");
    addr_top_a: assert property ((flash_addr_out >> (8 + ADDR_HI_BITS)) == 0)
        else $error("unimplemented address bit set");
endmodule

bind fic_ctrl fic_ctrl_monitor #(.ADDR_HI_BITS(ADDR_HI_BITS)) u_fic_ctrl_monitor (
    .clock_in(clock_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .cpu_stall_out(cpu_stall_out),
    .chip_reset_out(chip_reset_out), .flash_write_out(flash_write_out),
    .flash_erase_out(flash_erase_out), .flash_read_out(flash_read_out),
    .flash_buf_clear_out(flash_buf_clear_out), .flash_addr_out(flash_addr_out),
    .write_enabled_out(write_enabled_out), .flash_done_in(flash_done_in));

/* sim/tb_fic_ctrl.sv */
/* Self-checking bench for fic_ctrl with the flash array model.
   Assumes the checker binds itself to fic_ctrl. */
module tb_fic_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMO = 20;
    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    logic reg_wr_in = 1'h0;
    logic reg_rd_in = 1'h0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] delay = 8'h01;
    logic [3:0] seen = 4'h0;
    logic clr = 1'h0;
    wire [7:0] reg_rdata_out;
    wire [3:0] strb;
    wire [14:0] flash_addr_out;
    wire [63:0] flash_wdata_out;
    wire cpu_stall_out, chip_reset_out, write_enabled_out, flash_done_in;
    int err_count = 0, n_compared = 0, cyc = 0, n_rst = 0;
    logic [3:0] ta [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
    logic [7:0] td [5] = '{8'h84, 8'h94, 8'hb3, 8'hb1, 8'h01};
    logic [7:0] tl [5] = '{8'h01, 8'h09, 8'h04, 8'h01, 8'h03};
    logic [3:0] ts [5] = '{4'h1, 4'h2, 4'h4, 4'h0, 4'h8};
    fic_ctrl #(.ADDR_HI_BITS(7), .TIMEOUT_CYCLES(TMO)) u_fic_ctrl (
        .clock_in(clock_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .cpu_stall_out(cpu_stall_out), .chip_reset_out(chip_reset_out),
        .flash_write_out(strb[0]), .flash_erase_out(strb[1]), .flash_read_out(strb[2]),
        .flash_buf_clear_out(strb[3]), .flash_addr_out(flash_addr_out),
        .flash_wdata_out(flash_wdata_out), .write_enabled_out(write_enabled_out),
        .flash_done_in(flash_done_in));
    fic_flash_model u_fic_flash_model (.clock_in(clock_in), .rst_in(rst_in),
        .busy_in(|strb), .delay_in(delay), .done_out(flash_done_in));
    always #5 clock_in = ~clock_in;
    // ==========
    // Strobe record and hang guard
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        seen <= clr ? 4'h0 : seen | strb;
        n_rst <= n_rst + int'(chip_reset_out);
        if (cyc == 3000)
        begin
            err_count++;
            end_of_test();
        end
    end
    task automatic chk(input string s, input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'h1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string s);
        @(posedge clock_in);
        reg_rd_in <= 1'h1;
        reg_addr_in <= a;
        @(posedge clock_in);
        reg_rd_in <= 1'h0;
        @(posedge clock_in);
        #1 chk(s, reg_rdata_out, e);
    endtask
    task automatic op(input logic [3:0] a, input logic [7:0] d, input logic [7:0] dl);
        @(posedge clock_in);
        delay <= dl;
        clr <= 1'h1;
        wr(a, d);
        clr <= 1'h0;
        repeat (3) @(posedge clock_in);
        while (cpu_stall_out !== 1'h0 || strb !== 4'h0) @(posedge clock_in);
    endtask
    task automatic en(input logic [7:0] last, input logic [7:0] exp);
        logic [7:0] pat [5] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3};
        wr(4'h0, 8'h68);
        for (int k = 0; k < 5; k++)
            wr(4'(k + 7), pat[k]);
        wr(4'hc, last);
        repeat (TMO + 8) @(posedge clock_in);
        rd(4'h0, exp, "enable_result");
    endtask
    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'h0;
        rd(4'h0, 8'h70, "mode_cmd");
        for (int i = 1; i < 13; i++)
            rd(4'(i), 8'h00, "reset_value");
        $display("test reset values done");
        wr(4'h3, 8'ha5);
        wr(4'h4, 8'hff);
        wr(4'h2, 8'hfe);
        for (int i = 0; i < 8; i++)
            wr(4'(i + 5), 8'(8'h1b * (i + 1)));
        rd(4'h3, 8'ha5, "addr_low");
        rd(4'h4, 8'h7f, "addr_high");
        rd(4'h2, 8'h00, "buf_clear_reg");
        chk("addr_out", flash_addr_out, 15'h7fa5);
        for (int i = 0; i < 8; i++)
        begin
            rd(4'(i + 5), 8'(8'h1b * (i + 1)), "data_byte");
            chk("wdata_out", flash_wdata_out[8 * i +: 8], 8'(8'h1b * (i + 1)));
        end
        $display("test register access done");
        op(4'h0, 8'h84, 8'h01);
        rd(4'h0, 8'h00, "write_refused");
        chk("refused_strobes", seen, 4'h0);
        en(8'h41, 8'h60);
        en(8'h40, 8'he0);
        chk("enabled_out", write_enabled_out, 1'h1);
        $display("test enable procedure done");
        for (int j = 0; j < 5; j++)
        begin
            op(ta[j], td[j], tl[j]);
            rd(ta[j], td[j] & 8'hfa, "op_done");
            chk("op_strobe", seen, ts[j]);
        end
        $display("test flash operations done");
        wr(4'h1, 8'h54);
        wr(4'h1, 8'h55);
        repeat (3) @(posedge clock_in);
        chk("chip_resets", n_rst, 1);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00, "enable_cleared");
        chk("disabled_out", write_enabled_out, 1'h0);
        @(posedge clock_in);
        rst_in <= 1'h1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'h0;
        rd(4'h0, 8'h70, "mode_after_reset");
        $display("test chip reset and disable done");
        end_of_test();
    end
endmodule
